// ==== rwil_top.sv ====
// Reset entry and exit, external interrupt qualification and wake-up latency sequencer
// What the document requires of this block and of its reset and interrupt sources
// R1: The external reset source holds reset low at least sixteen core clock periods for it to count.
// R2: While external reset is asserted the address, data and control outputs are released to high impedance.
// R3: After reset release the first external address is driven 63 to 64 core clock periods later.
// R4: On power-on reset a stretcher may lengthen the wait before the first address to 2^21 clock periods.
// R5: An edge-sensitive interrupt requester holds its request at least one and a half clock periods.
// R6: After either interrupt line asserts, the service routine's first data access comes no sooner than 18T, 14T fast.
// R7: After either interrupt line asserts, the first general-purpose output change comes no sooner than 18T, 14T fast.
// R8: When line A wakes the device from wait, the first data access follows no sooner than 22T, 18T fast.
// R9: When line A wakes the device from stop, the first data access follows no sooner than 22T, 18T fast.
// R10: To leave stop, an edge request on line A is held at least one and a half clock periods.
// R11: In reset and stop the core clock runs at 8 MHz, a 125 ns period.
// R12: The interrupt fetch shows on the external pins only in operating mode three.
// R13: Reset and interrupt inputs are synchronised to the core clock before latencies are counted.
`timescale 1ns/1ps
`default_nettype none
module rwil_top
   import rwil_pkg::*;
#(
   parameter logic [21:0] POR_STRETCH_CYC = POR_STRETCH_DEF
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ext_reset_n,
   input  wire logic        ext_irq_line_a_n,
   input  wire logic        ext_irq_line_b_n,
   input  wire logic        irq_edge_mode,
   input  wire logic        irq_fast_path,
   input  wire logic        por_stretch_en,
   input  wire logic [1:0]  op_mode,
   input  wire logic        wait_req,
   input  wire logic        stop_req,
   output logic             bus_oe_n,
   output logic             first_addr_stb,
   output logic             isr_data_access,
   output logic             isr_gpo_valid,
   output logic             irq_fetch_pins,
   output logic             slow_clk_sel,
   output rwil_state_t      core_state
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (POR_STRETCH_CYC < FIRST_ADDR_MAX) begin : g_chk
      $error("POR_STRETCH_CYC shorter than the normal reset exit");
   end

   // Latency pick shared by interrupt entry and wake-up entry
   function automatic logic [21:0] lat_sel(input logic fast, input logic from_low_power);
      logic [21:0] r;
      r = 22'h00_0000;
      if (from_low_power) begin
         r = fast ? WAKE_LAT_FAST_CYC : WAKE_LAT_CYC;
      end else begin
         r = fast ? IRQ_LAT_FAST_CYC : IRQ_LAT_CYC;
      end
      return r;
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic        rsync1_reg, rsync2_reg;
   rwil_irq_t   isync1_reg, isync2_reg, idly_reg;
   rwil_irq_t   irq_raw;

   assign irq_raw = '{line_a: ~ext_irq_line_a_n, line_b: ~ext_irq_line_b_n};

   // Two flops; first stage feeds only the second, edge detect looks at stage two
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsync1_reg <= 1'b0;
         rsync2_reg <= 1'b0;
         isync1_reg <= '0;
         isync2_reg <= '0;
         idly_reg   <= '0;
      end else begin
         rsync1_reg <= ~ext_reset_n;   // R13
         rsync2_reg <= rsync1_reg;
         isync1_reg <= irq_raw;        // R13
         isync2_reg <= isync1_reg;
         idly_reg   <= isync2_reg;
      end
   end

   // Request qualification: edge mode needs a new assertion, level mode a held one
   logic hit_a, hit_b;
   assign hit_a = isync2_reg.line_a & (~irq_edge_mode | ~idly_reg.line_a); // R5 R10
   assign hit_b = isync2_reg.line_b & (~irq_edge_mode | ~idly_reg.line_b); // R5

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   rwil_state_t state_reg, state_next;
   logic [21:0] cnt_reg, cnt_next;
   logic [21:0] lat_reg, lat_next;
   logic [4:0]  rcnt_reg, rcnt_next;
   logic        por_reg, por_next;
   logic        oe_n_reg, oe_n_next;
   logic        addr_reg, addr_next;
   logic        acc_reg, acc_next;
   logic        gpo_reg, gpo_next;
   logic        fetch_reg, fetch_next;
   logic        slow_reg, slow_next;

   // Next-state logic; reset recognition overrides every other state
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      lat_next   = lat_reg;
      rcnt_next  = rcnt_reg;
      por_next   = por_reg;
      addr_next  = 1'b0;
      acc_next   = 1'b0;
      gpo_next   = 1'b0;
      oe_n_next  = oe_n_reg;
      // Count how long reset has been held; a shorter pulse is a glitch
      if (rsync2_reg) begin
         if (rcnt_reg != RESET_MIN_CYC[4:0]) begin
            rcnt_next = rcnt_reg + 5'h01;
         end
      end else begin
         rcnt_next = 5'h00;
      end
      case (state_reg)
         ST_RESET: begin
            cnt_next = 22'h00_0000;
            if (!rsync2_reg) begin
               state_next = ST_BOOT;
               // Stretch is only offered after power-on; later resets exit at 63T
               lat_next   = (por_reg && por_stretch_en) ? POR_STRETCH_CYC : FIRST_ADDR_CYC; // R4
            end
         end
         ST_BOOT: begin
            cnt_next = cnt_reg + 22'h00_0001;
            if (cnt_reg == lat_reg - 22'h00_0001) begin
               state_next = ST_RUN;  // R3
               addr_next  = 1'b1;    // R3
               oe_n_next  = 1'b0;
               por_next   = 1'b0;
            end
         end
         ST_RUN: begin
            cnt_next = 22'h00_0000;
            if (hit_a || hit_b) begin
               state_next = ST_ISR;
               lat_next   = lat_sel(irq_fast_path, 1'b0); // R6 R7
            end else if (stop_req) begin
               state_next = ST_STOP;
            end else if (wait_req) begin
               state_next = ST_WAIT;
            end
         end
         ST_ISR: begin
            cnt_next = cnt_reg + 22'h00_0001;
            if (cnt_reg == lat_reg - 22'h00_0001) begin
               state_next = ST_RUN;
               acc_next   = 1'b1;    // R6 R8 R9
               gpo_next   = 1'b1;    // R7
            end
         end
         ST_WAIT, ST_STOP: begin
            cnt_next = 22'h00_0000;
            // Of the two interrupt lines only line A brings the core out of a low-power state
            if (hit_a) begin
               state_next = ST_ISR;
               lat_next   = lat_sel(irq_fast_path, 1'b1); // R8 R9
            end
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
      // Bus floats as soon as reset is seen, before the hold is confirmed
      if (rsync2_reg) begin
         oe_n_next = 1'b1;        // R2
         addr_next = 1'b0;
         acc_next  = 1'b0;
         gpo_next  = 1'b0;
      end
      if (rcnt_next == RESET_MIN_CYC[4:0]) begin
         state_next = ST_RESET;   // R1
      end
      fetch_next = (state_next == ST_ISR) && (op_mode == MODE_EXT_FETCH); // R12
      slow_next  = (state_next == ST_RESET) || (state_next == ST_BOOT)
                || (state_next == ST_STOP);                               // R11
   end

   // Registers only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_RESET;
         cnt_reg   <= 22'h00_0000;
         lat_reg   <= FIRST_ADDR_CYC;
         rcnt_reg  <= 5'h00;
         por_reg   <= 1'b1;
         oe_n_reg  <= 1'b1;
         addr_reg  <= 1'b0;
         acc_reg   <= 1'b0;
         gpo_reg   <= 1'b0;
         fetch_reg <= 1'b0;
         slow_reg  <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         lat_reg   <= lat_next;
         rcnt_reg  <= rcnt_next;
         por_reg   <= por_next;
         oe_n_reg  <= oe_n_next;
         addr_reg  <= addr_next;
         acc_reg   <= acc_next;
         gpo_reg   <= gpo_next;
         fetch_reg <= fetch_next;
         slow_reg  <= slow_next;
      end
   end

   assign bus_oe_n        = oe_n_reg;
   assign first_addr_stb  = addr_reg;
   assign isr_data_access = acc_reg;
   assign isr_gpo_valid   = gpo_reg;
   assign irq_fetch_pins  = fetch_reg;
   assign slow_clk_sel    = slow_reg;
   assign core_state      = state_reg;

   // ----------------------------------------
   // Assertions and covers
   // ----------------------------------------
   // Cycles since the last reset release, for the boot window check;
   // saturates so a stretched power-on exit cannot wrap it into the window
   logic [6:0] rel_age_reg, rel_age_next;

   always_comb begin
      rel_age_next = rel_age_reg;
      if (rsync2_reg) begin
         rel_age_next = 7'h00;
      end else if (rel_age_reg != 7'h7F) begin
         rel_age_next = rel_age_reg + 7'h01;
      end
   end

   // Power-on counts as a release too, so its reset value is zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rel_age_reg <= 7'h00;
      end else begin
         rel_age_reg <= rel_age_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   float_in_reset_a: assert property (rsync2_reg |=> bus_oe_n) // R2
      else $error("bus driven while reset is held");
   reset_hold_a: assert property ($rose(rsync2_reg) ##1 rsync2_reg[*8] ##1 rsync2_reg[*7] |=> core_state == ST_RESET) // R1
      else $error("held reset not recognised after 16 cycles");
   short_boot_a: assert property ($fell(rsync2_reg) && core_state == ST_RESET && !(por_reg && por_stretch_en) // R3
      |-> ##[63:64] first_addr_stb)
      else $error("first address not 63 to 64 cycles after release");
   boot_window_a: assert property (first_addr_stb && lat_reg == FIRST_ADDR_CYC // R3
      |-> rel_age_reg >= FIRST_ADDR_CYC[6:0] && rel_age_reg <= FIRST_ADDR_MAX[6:0])
      else $error("first address outside the release window");
   addr_drive_a: assert property (first_addr_stb |-> !bus_oe_n && core_state == ST_RUN) // R3
      else $error("first address without bus drive");
   irq_norm_a: assert property (core_state == ST_RUN ##1 core_state == ST_ISR && lat_reg == IRQ_LAT_CYC // R6
      |-> !isr_data_access[*8] ##1 !isr_data_access[*8] ##1 !isr_data_access[*2] ##1 isr_data_access)
      else $error("service access not at 18 cycles");
   irq_fast_a: assert property (core_state == ST_RUN ##1 core_state == ST_ISR && lat_reg == IRQ_LAT_FAST_CYC
      |-> !isr_gpo_valid[*8] ##1 !isr_gpo_valid[*6]) // R7
      else $error("output change earlier than 14 cycles");
   wake_wait_a: assert property (core_state == ST_WAIT ##1 core_state == ST_ISR && !rsync2_reg
      |-> lat_reg == WAKE_LAT_CYC || lat_reg == WAKE_LAT_FAST_CYC) // R8
      else $error("wait wake-up latency too short");
   wake_stop_a: assert property (core_state == ST_STOP && !hit_a && !rsync2_reg |=> core_state == ST_STOP) // R9
      else $error("stop left without line A");
   slow_clock_a: assert property (core_state == ST_STOP || core_state == ST_RESET |-> slow_clk_sel) // R11
      else $error("fast clock in reset or stop");
   fetch_mode_a: assert property (irq_fetch_pins |-> core_state == ST_ISR && $past(op_mode) == MODE_EXT_FETCH) // R12
      else $error("fetch visible outside mode three");
   access_pair_a: assert property (isr_data_access |-> isr_gpo_valid && $past(core_state) == ST_ISR) // R6
      else $error("access without service state");

   boot_done_c:   cover property (first_addr_stb);
   isr_done_c:    cover property (core_state == ST_ISR ##[1:30] isr_data_access);
   stop_wake_c:   cover property (core_state == ST_STOP ##1 core_state == ST_ISR);
   wait_wake_c:   cover property (core_state == ST_WAIT ##1 core_state == ST_ISR);

endmodule
`default_nettype wire

// ==== rwil_pkg.sv ====
// Package holding the constants, types and states of the reset and wake latency sequencer
package rwil_pkg;

   // ----------------------------------------
   // Counter width and cycle figures, in core clock periods
   // ----------------------------------------
   localparam int unsigned CNT_W            = 22;
   localparam logic [21:0] RESET_MIN_CYC    = 22'h00_0010;   // 16T least reset hold
   localparam logic [21:0] FIRST_ADDR_CYC   = 22'h00_003F;   // 63T release to first address
   localparam logic [21:0] FIRST_ADDR_MAX   = 22'h00_0040;   // 64T latest first address
   localparam logic [21:0] POR_STRETCH_DEF  = 22'h20_0000;   // 2^21T stretched power-on reset
   localparam logic [21:0] IRQ_LAT_CYC      = 22'h00_0012;   // 18T
   localparam logic [21:0] IRQ_LAT_FAST_CYC = 22'h00_000E;   // 14T
   localparam logic [21:0] WAKE_LAT_CYC     = 22'h00_0016;   // 22T
   localparam logic [21:0] WAKE_LAT_FAST_CYC= 22'h00_0012;   // 18T

   // ----------------------------------------
   // Clock figures and operating modes
   // ----------------------------------------
   localparam int unsigned SLOW_CLK_NS      = 125;           // 8 MHz period used in reset and stop
   localparam logic [1:0]  MODE_EXT_FETCH   = 2'h3;          // Only mode with visible fetch

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic line_a;
      logic line_b;
   } rwil_irq_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_BOOT,
      ST_RUN,
      ST_ISR,
      ST_WAIT,
      ST_STOP
   } rwil_state_t;

endpackage

// ==== rwil_partner.sv ====
// Model of the external reset source and the two interrupt requesters
`timescale 1ns/1ps
`default_nettype none
module rwil_partner (
   input  wire logic clk_sys,
   output logic      ext_reset_n,
   output logic      ext_irq_line_a_n,
   output logic      ext_irq_line_b_n
);
   // Lines rest high, as pulled up, between requests
   initial begin
      ext_reset_n      = 1'b1;
      ext_irq_line_a_n = 1'b1;
      ext_irq_line_b_n = 1'b1;
   end

   // ----------------------------------------
   // Requests, changed just after a rising edge
   // ----------------------------------------
   // Never shorter than 18 so the synchroniser cannot eat into the minimum
   task automatic hold_reset(input int cyc);
      @(posedge clk_sys);
      #1 ext_reset_n = 1'b0;
      repeat ((cyc < 18) ? 18 : cyc) @(posedge clk_sys);
      #1 ext_reset_n = 1'b1;
   endtask

   // Two whole periods cover the one and a half period width
   task automatic raise_irq(input logic on_b, input int cyc);
      @(posedge clk_sys);
      #1;
      if (on_b) ext_irq_line_b_n = 1'b0;
      else ext_irq_line_a_n = 1'b0;
      repeat ((cyc < 2) ? 2 : cyc) @(posedge clk_sys);
      #1;
      ext_irq_line_a_n = 1'b1;
      ext_irq_line_b_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== rwil_tb_top.sv ====
// Self-checking testbench for the reset and wake latency sequencer
`timescale 1ns/1ps
`default_nettype none
module rwil_tb_top;
   import rwil_pkg::*;
   // Short stretch keeps the power-on exit cheap to simulate
   localparam logic [21:0] STRETCH = 22'h00_0080;
   logic        clk_sys = 1'b0;
   logic        rst, irq_edge_mode, irq_fast_path, por_stretch_en, wait_req, stop_req;
   logic [1:0]  op_mode;
   wire logic   ext_reset_n, ext_irq_line_a_n, ext_irq_line_b_n;
   logic        bus_oe_n, first_addr_stb, isr_data_access, isr_gpo_valid, irq_fetch_pins, slow_clk_sel;
   logic        fetch_seen;
   rwil_state_t core_state;
   int          n_errors = 0;
   int          checked = 0;

   always #12.5 clk_sys = ~clk_sys;

   rwil_top #(.POR_STRETCH_CYC(STRETCH)) i_rwil_top (
      .clk_sys(clk_sys), .rst(rst), .ext_reset_n(ext_reset_n), .ext_irq_line_a_n(ext_irq_line_a_n),
      .ext_irq_line_b_n(ext_irq_line_b_n), .irq_edge_mode(irq_edge_mode), .irq_fast_path(irq_fast_path),
      .por_stretch_en(por_stretch_en), .op_mode(op_mode), .wait_req(wait_req), .stop_req(stop_req),
      .bus_oe_n(bus_oe_n), .first_addr_stb(first_addr_stb), .isr_data_access(isr_data_access),
      .isr_gpo_valid(isr_gpo_valid), .irq_fetch_pins(irq_fetch_pins), .slow_clk_sel(slow_clk_sel),
      .core_state(core_state));

   rwil_partner i_rwil_partner (.clk_sys(clk_sys), .ext_reset_n(ext_reset_n),
      .ext_irq_line_a_n(ext_irq_line_a_n), .ext_irq_line_b_n(ext_irq_line_b_n));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Counts edges until a strobe shows; the bound stops a dead design hanging the run
   task automatic wait_strobe(input logic want_isr, output int n);
      for (n = 1; n <= 400; n++) begin
         @(posedge clk_sys);
         #1;
         if (n == 5) fetch_seen = irq_fetch_pins;
         if ((want_isr ? isr_data_access : first_addr_stb) === 1'b1) return;
      end
      n_errors++;
      conclude();
   endtask

   task automatic wait_state(input rwil_state_t s);
      for (int k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         #1;
         if (core_state === s) return;
      end
      n_errors++;
      conclude();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Power-on exit with the stretcher on waits the stretched count
   task automatic sc_por();
      int n;
      check(slow_clk_sel, 1);
      check(bus_oe_n, 1);
      wait_strobe(1'b0, n);
      check(n >= STRETCH && n <= STRETCH + 3, 1);
      check(bus_oe_n, 0);
   endtask

   // External reset floats the bus at once and is never stretched
   task automatic sc_ext_reset();
      int n;
      fork
         i_rwil_partner.hold_reset(20);
         begin
            repeat (4) @(posedge clk_sys);
            #2 check(bus_oe_n, 1);
         end
      join
      check(bus_oe_n, 1);
      check(slow_clk_sel, 1);
      check(core_state, ST_RESET);
      wait_strobe(1'b0, n);
      check(n >= 65 && n <= 67, 1);
      check(bus_oe_n, 0);
   endtask

   // Both lines, both speeds, both sensing modes; fetch visible only in mode three
   task automatic sc_irq_run();
      int n;
      for (int i = 0; i < 4; i++) begin
         irq_fast_path = i[0];
         op_mode = i[1] ? 2'h3 : 2'h0;
         irq_edge_mode = ~i[0];
         fork
            i_rwil_partner.raise_irq(i[1], i[0] ? 4 : 2);
            wait_strobe(1'b1, n);
         join
         // n counts from the edge that launches the pin: pin-to-pulse L+3 plus that edge
         check(n, (i[0] ? 14 : 18) + 4);
         check(isr_gpo_valid, 1);
         check(fetch_seen, i[1]);
         repeat (3) @(posedge clk_sys);
         #1;
      end
   endtask

   // Line B must not wake the core; line A wakes it with the longer latency
   task automatic sc_wake();
      int n;
      irq_edge_mode = 1'b1;
      for (int i = 0; i < 4; i++) begin
         irq_fast_path = i[0];
         stop_req = i[1];
         wait_req = ~i[1];
         wait_state(i[1] ? ST_STOP : ST_WAIT);
         if (i[1]) check(slow_clk_sel, 1);
         stop_req = 1'b0;
         wait_req = 1'b0;
         i_rwil_partner.raise_irq(1'b1, 2);
         repeat (4) @(posedge clk_sys);
         #1 check(core_state, i[1] ? ST_STOP : ST_WAIT);
         fork
            i_rwil_partner.raise_irq(1'b0, 2);
            wait_strobe(1'b1, n);
         join
         check(n, (i[0] ? 18 : 22) + 4);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      irq_edge_mode = 1'b1;
      irq_fast_path = 1'b0;
      por_stretch_en = 1'b1;
      op_mode = 2'h0;
      wait_req = 1'b0;
      stop_req = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 rst = 1'b0;
      sc_por();
      sc_ext_reset();
      sc_irq_run();
      sc_wake();
      conclude();
   end
endmodule
`default_nettype wire
